//--- common/psc_pkg.sv
// Address map, register offsets, reset values and types of the register bank
`default_nettype none
package psc_pkg;

    // ************************************************************
    // Bus and bank sizes
    // ************************************************************
    localparam int DATA_W       = 32;
    localparam int ADDR_W       = 32;
    localparam int PERIPH_NUM   = 8;
    localparam int PIDX_W       = 3;
    localparam int OFF_W        = 8;
    localparam int PERIPH_BUS_W = PERIPH_NUM * DATA_W;

    // ************************************************************
    // Address windows
    // ************************************************************
    // Window sizes as address bit counts: 16 Kbyte and 4 Kbyte
    localparam int PERIPH_WIN_BITS = 14;
    localparam int INTC_WIN_BITS   = 12;
    // Lowest address of the top 3 Mbyte of the 4 Gbyte space
    localparam logic [31:0] HIGH_AREA_BASE = 32'hFFD0_0000;
    localparam logic [31:0] PERIPH_BASE    = 32'hFFFC_0000;
    localparam logic [31:0] PERIPH_MASK    = 32'hFFFE_0000;
    localparam logic [31:0] PERIPH_HOLE    = 32'h0000_3F00;
    localparam logic [31:0] INTC_BASE      = 32'hFFFF_F000;
    localparam logic [31:0] INTC_MASK      = 32'hFFFF_F000;
    localparam logic [31:0] INTC_HOLE      = 32'h0000_0F00;

    // ************************************************************
    // Register offsets inside a peripheral window
    // ************************************************************
    localparam logic [7:0] OFF_CTRL_SET = 8'h00;
    localparam logic [7:0] OFF_CTRL_CLR = 8'h04;
    localparam logic [7:0] OFF_CTRL_VAL = 8'h08;
    localparam logic [7:0] OFF_MODE     = 8'h0C;
    localparam logic [7:0] OFF_DATA     = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;
    localparam logic [7:0] OFF_IEN_SET  = 8'h18;
    localparam logic [7:0] OFF_IEN_CLR  = 8'h1C;
    localparam logic [7:0] OFF_IEN_VAL  = 8'h20;
    localparam logic [7:0] OFF_IRQ_PEND = 8'h24;

    // Offsets inside the interrupt controller window
    localparam logic [7:0] OFF_INTC_SET  = 8'h00;
    localparam logic [7:0] OFF_INTC_CLR  = 8'h04;
    localparam logic [7:0] OFF_INTC_VAL  = 8'h08;
    localparam logic [7:0] OFF_INTC_PEND = 8'h0C;

    // ************************************************************
    // Reset values and word store layout
    // ************************************************************
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] IEN_RST     = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
    localparam logic [7:0]  INTC_EN_RST = 8'h00;
    localparam int          MEM_AW      = PIDX_W + 1;
    localparam int          MEM_DEPTH   = 16;
    localparam logic        SLOT_MODE   = 1'b0;
    localparam logic        SLOT_DATA   = 1'b1;

    // Bus transfer phase, one-hot
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b001,
        PH_SETUP  = 3'b010,
        PH_ACCESS = 3'b100
    } psc_phase_t;

endpackage
`default_nettype wire

//--- hw/psc_word_mem.sv
// Word store for mode and data registers with registered read data
`timescale 1ns/100ps
`default_nettype none
module psc_word_mem (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    // Write port
    input  wire logic                            wr_en,
    input  wire logic [psc_pkg::MEM_AW-1:0]      wr_addr,
    input  wire logic [psc_pkg::DATA_W-1:0]      wr_data,
    // Read port
    input  wire logic                            rd_en,
    input  wire logic [psc_pkg::MEM_AW-1:0]      rd_addr,
    output logic      [psc_pkg::DATA_W-1:0]      rd_data_ff
);

    logic [psc_pkg::DATA_W-1:0] mem [psc_pkg::MEM_DEPTH];

    // Array holds no reset so it maps onto plain storage
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= psc_pkg::RDATA_RST;
        end else if (rd_en) begin
            rd_data_ff <= mem[rd_addr];
        end
    end

endmodule
`default_nettype wire

//--- hw/psc_regmap.sv
// Peripheral bus register bank with set, clear and read aliases
//
// Overview of operation
// [RULE_01] Each peripheral owns a 16 Kbyte window inside the top 3 Mbyte.
// [RULE_02] The interrupt controller window decodes as 4 Kbyte only; the code decodes only its lowest 256 bytes.
// [RULE_03] Window base is its lowest address; offsets count upward from it.
// [RULE_04] Windows hold control, mode, data, status and interrupt registers.
// [RULE_05] Writing ones to the first alias sets those bits.
// [RULE_06] Writing ones to the second alias clears those bits.
// [RULE_07] Reading the third alias returns the stored value.
// [RULE_08] Zero bits written to set or clear aliases leave bits unchanged.
// [RULE_09] Processor reaches registers over the peripheral bus; we answer.
// [RULE_10] Multi-byte words are little-endian: byte 0 sits in bits 7:0.
// [RULE_11] Alias writes apply in their access cycle; clear beats set.
`timescale 1ns/100ps
`default_nettype none
module psc_regmap (
    // Clock and reset
    input  wire logic                                REF_CLK,
    input  wire logic                                NRST,
    // Peripheral bus slave
    input  wire logic                                PSEL,
    input  wire logic                                PENABLE,
    input  wire logic                                PWRITE,
    input  wire logic [psc_pkg::ADDR_W-1:0]          PADDR,
    input  wire logic [psc_pkg::DATA_W-1:0]          PWDATA,
    output logic      [psc_pkg::DATA_W-1:0]          PRDATA,
    // Peripheral side
    input  wire logic [psc_pkg::PERIPH_BUS_W-1:0]    PERIPH_STATUS,
    output logic      [psc_pkg::PERIPH_BUS_W-1:0]    PERIPH_CTRL,
    output logic      [psc_pkg::PERIPH_BUS_W-1:0]    PERIPH_IEN,
    // Interrupt controller side
    output logic      [psc_pkg::PERIPH_NUM-1:0]      INTC_EN,
    output logic      [psc_pkg::PERIPH_NUM-1:0]      INTC_PEND
);

    // ************************************************************
    // Decode and update helpers
    // ************************************************************

    // Hit when inside the high area, matching base and with no
    // address bits set in the unused upper part of the window
    function automatic logic win_hit(
        input logic [31:0] a,
        input logic [31:0] base,
        input logic [31:0] mask,
        input logic [31:0] hole
    );
        win_hit = (a >= psc_pkg::HIGH_AREA_BASE) &&
                  ((a & mask) == base) &&
                  ((a & hole) == '0);
    endfunction

    function automatic logic [psc_pkg::PIDX_W-1:0] periph_index(
        input logic [31:0] a
    );
        periph_index = a[psc_pkg::PERIPH_WIN_BITS +: psc_pkg::PIDX_W];
    endfunction

    function automatic logic [psc_pkg::OFF_W-1:0] reg_offset(
        input logic [31:0] a
    );
        reg_offset = a[psc_pkg::OFF_W-1:0];
    endfunction

    // Clear mask is applied last so it wins over a set of the same bit
    function automatic logic [31:0] apply_alias(
        input logic [31:0] cur,
        input logic [31:0] set_w,
        input logic [31:0] clr_w
    );
        apply_alias = (cur | set_w) & ~clr_w;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int N = psc_pkg::PERIPH_NUM;

    psc_pkg::psc_phase_t              phase_ff;
    psc_pkg::psc_phase_t              nxt_phase;
    logic                             p_hit;
    logic                             i_hit;
    logic [psc_pkg::PIDX_W-1:0]       pidx;
    logic [psc_pkg::OFF_W-1:0]        off;
    logic                             setup_cyc;
    logic                             wr_stb;
    logic                             rd_req;
    logic [psc_pkg::DATA_W-1:0]       ctrl_ff   [N];
    logic [psc_pkg::DATA_W-1:0]       ien_ff    [N];
    logic [psc_pkg::DATA_W-1:0]       status_w  [N];
    logic [psc_pkg::DATA_W-1:0]       pend_w    [N];
    logic [psc_pkg::DATA_W-1:0]       ctrl_set  [N];
    logic [psc_pkg::DATA_W-1:0]       ctrl_clr  [N];
    logic [psc_pkg::DATA_W-1:0]       ien_set   [N];
    logic [psc_pkg::DATA_W-1:0]       ien_clr   [N];
    logic [N-1:0]                     intc_en_ff;
    logic [N-1:0]                     intc_src;
    logic [N-1:0]                     intc_set;
    logic [N-1:0]                     intc_clr;
    logic [psc_pkg::DATA_W-1:0]       rd_val;
    logic                             rd_mem;
    logic [psc_pkg::DATA_W-1:0]       rd_ff;
    logic                             from_mem_ff;
    logic                             mem_we;
    logic                             mem_re;
    logic [psc_pkg::MEM_AW-1:0]       mem_addr;
    logic [psc_pkg::DATA_W-1:0]       mem_q;

    // ************************************************************
    // Address decode
    // ************************************************************
    assign p_hit = win_hit(PADDR, psc_pkg::PERIPH_BASE,
                           psc_pkg::PERIPH_MASK,
                           psc_pkg::PERIPH_HOLE);  // [RULE_01]
    assign i_hit = win_hit(PADDR, psc_pkg::INTC_BASE,
                           psc_pkg::INTC_MASK,
                           psc_pkg::INTC_HOLE);    // [RULE_02]
    assign pidx  = periph_index(PADDR);            // [RULE_03]
    assign off   = reg_offset(PADDR);              // [RULE_03]

    // ************************************************************
    // Bus transfer phases
    // ************************************************************
    always_comb begin
        nxt_phase = psc_pkg::PH_IDLE;
        case (phase_ff)
            psc_pkg::PH_SETUP: begin
                if (PSEL && PENABLE) begin
                    nxt_phase = psc_pkg::PH_ACCESS;
                end else if (PSEL) begin
                    nxt_phase = psc_pkg::PH_SETUP;
                end
            end
            default: begin
                if (PSEL && !PENABLE) begin
                    nxt_phase = psc_pkg::PH_SETUP;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            phase_ff <= psc_pkg::PH_IDLE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // A write lands only in an access cycle that follows its setup cycle
    assign setup_cyc = PSEL && !PENABLE;
    assign wr_stb    = (phase_ff == psc_pkg::PH_SETUP) && PSEL &&
                       PENABLE && PWRITE;                // [RULE_09]
    assign rd_req    = setup_cyc && !PWRITE;

    // ************************************************************
    // Alias strobes
    // ************************************************************
    // Only ones in the written word reach the masks
    always_comb begin
        for (int i = 0; i < N; i++) begin
            ctrl_set[i] = '0;
            ctrl_clr[i] = '0;
            ien_set[i]  = '0;
            ien_clr[i]  = '0;
            if (wr_stb && p_hit && (pidx == psc_pkg::PIDX_W'(i))) begin
                if (off == psc_pkg::OFF_CTRL_SET) begin
                    ctrl_set[i] = PWDATA;                // [RULE_05]
                end else if (off == psc_pkg::OFF_CTRL_CLR) begin
                    ctrl_clr[i] = PWDATA;                // [RULE_06]
                end else if (off == psc_pkg::OFF_IEN_SET) begin
                    ien_set[i] = PWDATA;                 // [RULE_05]
                end else if (off == psc_pkg::OFF_IEN_CLR) begin
                    ien_clr[i] = PWDATA;                 // [RULE_06]
                end
            end
        end
    end

    always_comb begin
        intc_set = '0;
        intc_clr = '0;
        if (wr_stb && i_hit) begin
            if (off == psc_pkg::OFF_INTC_SET) begin
                intc_set = PWDATA[N-1:0];                // [RULE_05]
            end else if (off == psc_pkg::OFF_INTC_CLR) begin
                intc_clr = PWDATA[N-1:0];                // [RULE_06]
            end
        end
    end

    // ************************************************************
    // Control and interrupt enable registers
    // ************************************************************
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < N; i++) begin
                ctrl_ff[i] <= psc_pkg::CTRL_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                ctrl_ff[i] <= apply_alias(ctrl_ff[i], ctrl_set[i],
                                          ctrl_clr[i]); // [RULE_08] [RULE_11]
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < N; i++) begin
                ien_ff[i] <= psc_pkg::IEN_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                ien_ff[i] <= apply_alias(ien_ff[i], ien_set[i],
                                         ien_clr[i]);   // [RULE_08] [RULE_11]
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            intc_en_ff <= psc_pkg::INTC_EN_RST;
        end else begin
            intc_en_ff <= (intc_en_ff | intc_set) & ~intc_clr; // [RULE_11]
        end
    end

    // ************************************************************
    // Peripheral side wiring
    // ************************************************************
    // Bit 0 of each word is bit 0 of the byte at the lowest address
    for (genvar g = 0; g < N; g++) begin : g_periph
        assign status_w[g] = PERIPH_STATUS[g*psc_pkg::DATA_W +:
                                           psc_pkg::DATA_W];   // [RULE_10]
        assign pend_w[g]   = status_w[g] & ien_ff[g];
        assign intc_src[g] = |pend_w[g];
        assign PERIPH_CTRL[g*psc_pkg::DATA_W +: psc_pkg::DATA_W] =
            ctrl_ff[g];
        assign PERIPH_IEN[g*psc_pkg::DATA_W +: psc_pkg::DATA_W] =
            ien_ff[g];
    end

    assign INTC_EN   = intc_en_ff;
    assign INTC_PEND = intc_src & intc_en_ff;

    // ************************************************************
    // Read selection
    // ************************************************************
    // Set and clear aliases are write-only and read as zero
    always_comb begin
        rd_val = '0;
        rd_mem = 1'b0;
        if (p_hit) begin
            if (off == psc_pkg::OFF_CTRL_VAL) begin
                rd_val = ctrl_ff[pidx];                  // [RULE_07]
            end else if (off == psc_pkg::OFF_MODE) begin
                rd_mem = 1'b1;                           // [RULE_04]
            end else if (off == psc_pkg::OFF_DATA) begin
                rd_mem = 1'b1;                           // [RULE_04]
            end else if (off == psc_pkg::OFF_STATUS) begin
                rd_val = status_w[pidx];                 // [RULE_04]
            end else if (off == psc_pkg::OFF_IEN_VAL) begin
                rd_val = ien_ff[pidx];                   // [RULE_07]
            end else if (off == psc_pkg::OFF_IRQ_PEND) begin
                rd_val = pend_w[pidx];                   // [RULE_04]
            end
        end else if (i_hit) begin
            if (off == psc_pkg::OFF_INTC_VAL) begin
                rd_val = psc_pkg::DATA_W'(intc_en_ff);   // [RULE_07]
            end else if (off == psc_pkg::OFF_INTC_PEND) begin
                rd_val = psc_pkg::DATA_W'(INTC_PEND);
            end
        end
    end

    // Read data is captured in the setup cycle so it is steady
    // for the whole access cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_ff       <= psc_pkg::RDATA_RST;
            from_mem_ff <= 1'b0;
        end else if (rd_req) begin
            rd_ff       <= rd_val;
            from_mem_ff <= rd_mem;
        end
    end

    assign PRDATA = from_mem_ff ? mem_q : rd_ff;          // [RULE_09]

    // ************************************************************
    // Mode and data word store
    // ************************************************************
    assign mem_we   = wr_stb && p_hit &&
                      ((off == psc_pkg::OFF_MODE) ||
                       (off == psc_pkg::OFF_DATA));      // [RULE_04]
    assign mem_re   = rd_req && rd_mem;
    assign mem_addr = {pidx, (off == psc_pkg::OFF_DATA) ?
                             psc_pkg::SLOT_DATA : psc_pkg::SLOT_MODE};

    psc_word_mem u_word_mem (
        .clk        (REF_CLK),
        .rst_n      (NRST),
        .wr_en      (mem_we),
        .wr_addr    (mem_addr),
        .wr_data    (PWDATA),
        .rd_en      (mem_re),
        .rd_addr    (mem_addr),
        .rd_data_ff (mem_q)
    );

endmodule
`default_nettype wire

//--- bench/psc_regmap_assertions.sv
// Port-level checks of the peripheral register bank
`timescale 1ns/100ps
`default_nettype none
module psc_regmap_assertions (
    // Clock and reset
    input wire logic         REF_CLK,
    input wire logic         NRST,
    // Peripheral bus
    input wire logic         PSEL,
    input wire logic         PENABLE,
    input wire logic         PWRITE,
    input wire logic [31:0]  PADDR,
    input wire logic [31:0]  PWDATA,
    input wire logic [31:0]  PRDATA,
    // Peripheral and interrupt side
    input wire logic [255:0] PERIPH_STATUS,
    input wire logic [255:0] PERIPH_CTRL,
    input wire logic [255:0] PERIPH_IEN,
    input wire logic [7:0]   INTC_EN,
    input wire logic [7:0]   INTC_PEND
);
    // ************************************************************
    // Decode of the current bus cycle
    // ************************************************************
    logic            setup_ff;
    logic [2:0]      idx_ff;
    logic [31:0]     ctrl_ff;
    logic [31:0]     ien_ff;
    logic [31:0]     wd_ff;
    logic [7:0]      en_ff;
    logic [7:0]      pend;
    wire logic [2:0] idx  = PADDR[16:14];
    wire logic [7:0] off  = PADDR[7:0];
    wire logic       pwin = (PADDR & psc_pkg::PERIPH_MASK) ==
                            psc_pkg::PERIPH_BASE && PADDR[13:8] == 6'h00;
    wire logic       iwin = (PADDR & psc_pkg::INTC_MASK) ==
                            psc_pkg::INTC_BASE && PADDR[11:8] == 4'h0;
    // Only an access that follows a setup counts as a write
    wire logic       wr   = PSEL && PENABLE && PWRITE && setup_ff;
    wire logic       rs   = PSEL && !PENABLE && !PWRITE;
    wire logic       cs   = wr && pwin && off == psc_pkg::OFF_CTRL_SET;
    wire logic       cc   = wr && pwin && off == psc_pkg::OFF_CTRL_CLR;
    wire logic       ic   = wr && pwin && off == psc_pkg::OFF_IEN_CLR;
    wire logic       es   = wr && iwin && off == psc_pkg::OFF_INTC_SET;
    wire logic [31:0] ctrl_now = PERIPH_CTRL[32*idx_ff +: 32];
    wire logic [31:0] ien_now  = PERIPH_IEN[32*idx_ff +: 32];

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            setup_ff <= 1'b0;
        end
        else begin
            setup_ff <= PSEL && !PENABLE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        idx_ff  <= idx;
        ctrl_ff <= PERIPH_CTRL[32*idx +: 32];
        ien_ff  <= PERIPH_IEN[32*idx +: 32];
        wd_ff   <= PWDATA;
        en_ff   <= INTC_EN;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pend[i] = INTC_EN[i] && |(PERIPH_STATUS[32*i +: 32] &
                                      PERIPH_IEN[32*i +: 32]);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    a_ctrl_set_or: assert property (
        cs |=> ctrl_now == (ctrl_ff | wd_ff))
        else $error("control set alias did not OR the word in");
    a_ctrl_clr_andn: assert property (
        cc |=> ctrl_now == (ctrl_ff & ~wd_ff))
        else $error("control clear alias did not clear the ones");
    a_ien_clr_andn: assert property (
        ic |=> ien_now == (ien_ff & ~wd_ff))
        else $error("enable clear alias did not clear the ones");
    a_ctrl_only_alias: assert property (
        !(cs || cc) |=> $stable(PERIPH_CTRL))
        else $error("control changed without an alias write");
    a_intc_set_or: assert property (
        es |=> INTC_EN == (en_ff | wd_ff[7:0]))
        else $error("interrupt enable set did not OR the byte in");
    a_pend_view: assert property (
        INTC_PEND == pend)
        else $error("pending lines differ from status and enables");
    a_read_ctrl: assert property (
        rs && pwin && off == psc_pkg::OFF_CTRL_VAL |=> PRDATA == ctrl_ff)
        else $error("control read alias returned a wrong value");
    a_unmapped_zero: assert property (
        rs && !pwin && !iwin |=> PRDATA == 32'h0000_0000)
        else $error("read outside the windows was not zero");
    a_rdata_holds: assert property (
        !rs |=> $stable(PRDATA))
        else $error("read data moved without a read setup");
endmodule
`default_nettype wire

//--- bench/psc_host_model.sv
// Bus master model standing in for the processor behind the bridge
`timescale 1ns/100ps
`default_nettype none
module psc_host_model (
    // Clock
    input  wire logic        REF_CLK,
    // Peripheral bus master
    output logic             PSEL,
    output logic             PENABLE,
    output logic             PWRITE,
    output logic [31:0]      PADDR,
    output logic [31:0]      PWDATA,
    input  wire logic [31:0] PRDATA
);
    initial begin
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PWRITE  = 1'b0;
        PADDR   = 32'h0000_0000;
        PWDATA  = 32'h0000_0000;
    end

    // Setup then one access cycle; returns on the edge ending the access
    // so a following call starts the next setup back to back
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(negedge REF_CLK);
        PSEL    = 1'b1;
        PENABLE = 1'b0;
        PWRITE  = wr;
        PADDR   = a;
        PWDATA  = wr ? d : ~PWDATA;
        @(negedge REF_CLK);
        PENABLE = 1'b1;
        @(posedge REF_CLK);
        q = PRDATA;
    endtask

    // Released address and data lines show the inverse of their last value; PWRITE holds
    task automatic idle();
        @(negedge REF_CLK);
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PADDR   = ~PADDR;
        PWDATA  = ~PWDATA;
    endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the peripheral register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic         ref_clk;
    logic         nrst;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [31:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic [255:0] status;
    logic [255:0] ctrl;
    logic [255:0] ien;
    logic [7:0]   intc_en;
    logic [7:0]   intc_pend;
    int           bad_count;
    int           n_compared;
    int           cycles;

    psc_host_model i_host (.REF_CLK(ref_clk), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata));

    psc_regmap i_dut (.REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PERIPH_STATUS(status),
        .PERIPH_CTRL(ctrl), .PERIPH_IEN(ien), .INTC_EN(intc_en),
        .INTC_PEND(intc_pend));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end
        else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    function automatic logic [31:0] ad(int i, logic [7:0] o);
        return psc_pkg::PERIPH_BASE + 32'(i) * 32'h0000_4000 + {24'h0, o};
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input string n, input logic [31:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 32'h0000_0000, q);
        check(n, e, q);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_alias();
        logic [31:0] a;
        for (int i = 0; i < 8; i++) begin
            a = 32'hA5A5_0000 | 32'(i);
            check("ctrl at reset", 32'h0, ctrl[32*i +: 32]);
            wr(ad(i, psc_pkg::OFF_CTRL_SET), a);
            #1;
            check("ctrl after set", a, ctrl[32*i +: 32]);
            wr(ad(i, psc_pkg::OFF_CTRL_SET), 32'h0000_0F00);
            wr(ad(i, psc_pkg::OFF_CTRL_CLR), 32'h8000_0101);
            wr(ad(i, psc_pkg::OFF_CTRL_CLR), 32'h0000_0000);
            rd("ctrl value", ad(i, psc_pkg::OFF_CTRL_VAL),
               32'h25A5_0E00 | 32'(i & 6));
            rd("set alias", ad(i, psc_pkg::OFF_CTRL_SET), 32'h0);
            wr(ad(i, psc_pkg::OFF_IEN_SET), 32'h0000_00FF);
            wr(ad(i, psc_pkg::OFF_IEN_CLR), 32'h0000_000F);
            rd("ien value", ad(i, psc_pkg::OFF_IEN_VAL), 32'hF0);
        end
        for (int i = 0; i < 8; i++) begin
            check("ctrl out", 32'h25A5_0E00 | 32'(i & 6),
                  ctrl[32*i +: 32]);
            check("ien out", 32'hF0, ien[32*i +: 32]);
        end
    endtask

    task automatic t_map();
        wr(ad(2, psc_pkg::OFF_CTRL_SET) | 32'h100, 32'hFFFF_FFFF);
        rd("hole ignored", ad(2, psc_pkg::OFF_CTRL_VAL),
           32'h25A5_0E02);
        rd("below windows", ad(0, 8'h00) - 32'h4000, 32'h0);
        wr(ad(5, psc_pkg::OFF_MODE), 32'h4433_2211);
        wr(ad(5, psc_pkg::OFF_DATA), 32'h8877_6655);
        rd("mode word", ad(5, psc_pkg::OFF_MODE), 32'h4433_2211);
        rd("data word", ad(5, psc_pkg::OFF_DATA), 32'h8877_6655);
        rd("status", ad(3, psc_pkg::OFF_STATUS), 32'h0618);
        rd("irq pend", ad(3, psc_pkg::OFF_IRQ_PEND), 32'h10);
        wr(psc_pkg::INTC_BASE, 32'h0000_00A5);
        wr(psc_pkg::INTC_BASE + 32'h4, 32'h0000_0021);
        wr(psc_pkg::INTC_BASE + 32'h100, 32'h0000_00FF);
        rd("intc en", psc_pkg::INTC_BASE + 32'h8, 32'h84);
        rd("outside intc", psc_pkg::INTC_BASE - 32'h1000, 32'h0);
        rd("intc pend", psc_pkg::INTC_BASE + 32'hC, 32'h80);
        i_host.idle();
        status[64 +: 32] = 32'h0000_0010;
        #1;
        check("pend live", 32'h84, {24'h0, intc_pend});
        check("intc en out", 32'h84, {24'h0, intc_en});
    endtask

    // ************************************************************
    // Clock, reset, sequence and watchdog
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        nrst = 1'b0;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        for (int i = 0; i < 8; i++) begin
            status[32*i +: 32] = 32'h0000_00C3 << i;
        end
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        check("rdata at reset", 32'h0, prdata);
        t_alias();
        t_map();
        wrap_up();
    end
endmodule

bind psc_regmap psc_regmap_assertions i_chk (.REF_CLK(REF_CLK),
    .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PERIPH_STATUS(PERIPH_STATUS), .PERIPH_CTRL(PERIPH_CTRL),
    .PERIPH_IEN(PERIPH_IEN), .INTC_EN(INTC_EN), .INTC_PEND(INTC_PEND));
`default_nettype wire
